// File: hw/phy_special_modes_defines.svh
`ifndef PHY_SPECIAL_MODES_DEFINES_SVH
`define PHY_SPECIAL_MODES_DEFINES_SVH

// management register index of the special modes register
`define PSM_REG_INDEX 5'h12
// width of the management register index
`define PSM_INDEX_W 5
// width of the register itself
`define PSM_DATA_W 16
// mode field position
`define PSM_MODE_MSB 7
`define PSM_MODE_LSB 5
// address field position
`define PSM_ADDR_MSB 4
`define PSM_ADDR_LSB 0
// mode default when the negotiation strap is high
`define PSM_MODE_ALL_CAPABLE 3'h7
// value that reserved bits return
`define PSM_RESERVED_VALUE 8'h00
// synchroniser stages on each strap pin, ahead of the level register
`define PSM_SYNC_STAGES 3

`endif

// File: hw/phy_special_modes_pkg.sv
package phy_special_modes_pkg;

  // operating modes held in the mode field
  typedef enum logic [2:0] {
    MODE_10_HALF = 3'h0,
    MODE_10_FULL = 3'h1,
    MODE_100_HALF = 3'h2,
    MODE_100_FULL = 3'h3,
    MODE_AN_100_HALF = 3'h4,
    MODE_REPEATER = 3'h5,
    MODE_POWER_DOWN = 3'h6,
    MODE_ALL_CAPABLE = 3'h7
  } phy_mode_t;

  // what one mode drives into the control and advertisement registers
  typedef struct packed {
    logic [3:0] ctrl_drive;  // basic control bits 13,12,10,8 driven
    logic [3:0] ctrl_value;  // their values
    logic [3:0] adv_drive;   // advertisement bits 8..5 driven
    logic [3:0] adv_value;   // their values
    logic power_down;        // power-down operation
    logic repeater;          // repeater operation
    logic crs_on_tx;         // carrier sense on transmit as well
  } mode_effect_t;

endpackage : phy_special_modes_pkg

// File: hw/strap_sync.sv
`timescale 1ns/10ps
`include "phy_special_modes_defines.svh"

// three-stage strap synchroniser; a change counts when stages two and
// three agree
module strap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  // synchroniser chain, left free of reset so it is settled at release
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  // bits where the last two stages agree
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  // filtered value
  wire [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level);

  // chain shifts every edge, also during reset
  always_ff @(posedge clk) begin
    stage1 <= pin;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  // filtered level follows the chain once it agrees
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level <= next_level;
    end else begin
      level <= next_level;
    end
  end

endmodule : strap_sync

// File: hw/phy_special_modes_register.sv
`timescale 1ns/10ps
`include "phy_special_modes_defines.svh"

module phy_special_modes_register #(
  parameter int NUM_PORTS = 2,
  parameter int PORT_W = 1,
  parameter logic [4:0] ADDR_BASE_SEL0 = 5'h01,  // address of port 0, strap low
  parameter logic [4:0] ADDR_BASE_SEL1 = 5'h11   // address of port 0, strap high
) (
  input wire logic clk,
  input wire logic rst_n,
  // management access by register index
  input wire logic mgmt_wr_en,
  input wire logic mgmt_rd_en,
  input wire logic [PORT_W-1:0] mgmt_port,
  input wire logic [`PSM_INDEX_W-1:0] mgmt_index,
  input wire logic [`PSM_DATA_W-1:0] mgmt_wdata,
  output logic [`PSM_DATA_W-1:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // configuration loader writes
  input wire logic cfg_load_en,
  input wire logic [PORT_W-1:0] cfg_load_port,
  input wire logic [`PSM_DATA_W-1:0] cfg_load_data,
  // per-port PHY reset from the chip reset control
  input wire logic [NUM_PORTS-1:0] port_phy_reset,
  // configuration straps, asynchronous pins
  input wire logic [NUM_PORTS-1:0] autoneg_strap,
  input wire logic [NUM_PORTS-1:0] speed_strap,
  input wire logic [NUM_PORTS-1:0] duplex_strap,
  input wire logic phy_addr_sel_strap,
  // per-port results, packed port 0 in the low bits
  output logic [5*NUM_PORTS-1:0] phy_mgmt_address,
  output logic [5*NUM_PORTS-1:0] scrambler_seed,
  output logic [4*NUM_PORTS-1:0] ctrl_drive,
  output logic [4*NUM_PORTS-1:0] ctrl_value,
  output logic [4*NUM_PORTS-1:0] adv_drive,
  output logic [4*NUM_PORTS-1:0] adv_value,
  output logic [NUM_PORTS-1:0] power_down,
  output logic [NUM_PORTS-1:0] repeater_mode,
  output logic [NUM_PORTS-1:0] crs_on_tx
);

  // refuse sizes the port select cannot serve
  generate
    if (NUM_PORTS < 1 || NUM_PORTS > 16) begin : g_bad_ports
      $error("NUM_PORTS must lie in 1..16");
    end
    if ((1 << PORT_W) < NUM_PORTS) begin : g_bad_port_w
      $error("PORT_W too narrow for NUM_PORTS");
    end
  endgenerate

  // mode decode into control and advertisement bit effects
  // control bits are packed {13,12,10,8}, bit 3 standing for 13
  // advertisement bits are packed {8,7,6,5}, bit 3 standing for 8
  // a drive bit low means the mode leaves that bit to its register
  // values under a low drive bit are held at zero, never left open
  // forced modes drive all four control bits, no advertisement bits
  // negotiated modes drive both groups
  // power-down drives nothing: the control bits keep their own state
  // all-capable leaves bits 13 and 8 to the control register
  // carrier on transmit is a flag for the carrier sense logic
  // repeater is a flag for the half-duplex repeater path
  // the default branch only catches unknown codes in simulation
  function automatic phy_special_modes_pkg::mode_effect_t decode_mode(
    input logic [2:0] mode
  );
    phy_special_modes_pkg::mode_effect_t eff;
    eff = '0;
    case (phy_special_modes_pkg::phy_mode_t'(mode))
      phy_special_modes_pkg::MODE_10_HALF: begin
        eff.ctrl_drive = 4'hf;
        eff.ctrl_value = 4'h0;
      end
      phy_special_modes_pkg::MODE_10_FULL: begin
        eff.ctrl_drive = 4'hf;
        eff.ctrl_value = 4'h1;
      end
      phy_special_modes_pkg::MODE_100_HALF: begin
        eff.ctrl_drive = 4'hf;
        eff.ctrl_value = 4'h8;
        eff.crs_on_tx = 1'b1;
      end
      phy_special_modes_pkg::MODE_100_FULL: begin
        eff.ctrl_drive = 4'hf;
        eff.ctrl_value = 4'h9;
      end
      phy_special_modes_pkg::MODE_AN_100_HALF: begin
        eff.ctrl_drive = 4'hf;
        eff.ctrl_value = 4'hc;
        eff.adv_drive = 4'hf;
        eff.adv_value = 4'h4;
        eff.crs_on_tx = 1'b1;
      end
      phy_special_modes_pkg::MODE_REPEATER: begin
        eff.ctrl_drive = 4'hf;
        eff.ctrl_value = 4'hc;
        eff.adv_drive = 4'hf;
        eff.adv_value = 4'h4;
        eff.repeater = 1'b1;
      end
      phy_special_modes_pkg::MODE_POWER_DOWN: begin
        eff.power_down = 1'b1;
      end
      phy_special_modes_pkg::MODE_ALL_CAPABLE: begin
        eff.ctrl_drive = 4'h6;
        eff.ctrl_value = 4'h4;
        eff.adv_drive = 4'hf;
        eff.adv_value = 4'hf;
        eff.crs_on_tx = 1'b1;
      end
      default: begin
        eff = '0;
      end
    endcase
    return eff;
  endfunction : decode_mode

  // strap mode default for one port
  function automatic logic [2:0] strap_mode(
    input logic an,
    input logic spd,
    input logic dpx
  );
    logic [2:0] m;
    m = an ? `PSM_MODE_ALL_CAPABLE : {1'b0, spd, dpx};
    return m;
  endfunction : strap_mode

  // strap pins change only at power-up, yet they are asynchronous
  // to clk, so each passes three synchroniser stages and the level register before it is used
  // reset must last long enough for the chain to fill; four edges
  // of reset are the least that keeps the release value clean
  // a strap that moves after release is ignored until the next
  // release, since only the release cycle copies it into a field
  // synchronised strap levels
  logic [NUM_PORTS-1:0] an_sync;
  logic [NUM_PORTS-1:0] spd_sync;
  logic [NUM_PORTS-1:0] dpx_sync;
  logic addr_sel_sync;

  // one synchroniser for all strap pins
  strap_sync #(
    .WIDTH(3 * NUM_PORTS + 1)
  ) u_strap_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({phy_addr_sel_strap, duplex_strap, speed_strap, autoneg_strap}),
    .level({addr_sel_sync, dpx_sync, spd_sync, an_sync})
  );

  // high once the first cycle after reset release has passed
  logic released;
  // release cycle marker
  wire release_now = rst_n & ~released;

  // release tracker
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      released <= 1'b0;
    end else begin
      released <= 1'b1;
    end
  end

  // the address select strap needs no latch of its own
  // the address field takes it in the release cycle only
  // a port PHY reset leaves the address alone, so nothing
  // reads the strap again after release
  // keeping a copy would leave a register nobody reads
  // the mode default, by contrast, is latched per port,
  // because a port PHY reset restores it later on
  // both defaults come from the synchronised level of the
  // release cycle, so they belong to one and the same moment
  // a second chip reset captures the straps afresh
  // software must hand out distinct addresses itself,
  // nothing here compares the ports' addresses

  // access decode shared by read and write
  wire index_hit = (mgmt_index == `PSM_REG_INDEX);
  wire port_ok = (32'(mgmt_port) < NUM_PORTS);
  wire wr_hit = mgmt_wr_en & index_hit & port_ok;
  wire rd_hit = mgmt_rd_en & index_hit & port_ok;
  wire load_ok = cfg_load_en & (32'(cfg_load_port) < NUM_PORTS);

  // register contents of every port, port 0 low
  wire [3*NUM_PORTS-1:0] mode_all;
  wire [5*NUM_PORTS-1:0] addr_all;

  // priority inside a port, highest first:
  // release cycle loads both fields from the straps
  // port PHY reset restores the latched mode default only
  // loader write beats a host write of the same cycle
  // host write lands when nothing above it is active
  // the decoded outputs are one edge behind the fields,
  // so a write shows on them two edges after its strobe
  // the address output and the scrambler seed are one value
  // per-port register and decode
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
      // stored fields
      logic [2:0] mode;
      logic [4:0] addr;
      // latched strap mode, used again by a port PHY reset
      logic [2:0] mode_default;
      // decoded effect of the stored mode
      phy_special_modes_pkg::mode_effect_t eff;
      // this port's access strobes
      wire host_wr = wr_hit & (32'(mgmt_port) == p);
      wire load_wr = load_ok & (32'(cfg_load_port) == p);
      // strap-derived defaults at release
      wire [2:0] mode_at_release = strap_mode(an_sync[p], spd_sync[p], dpx_sync[p]);
      wire [4:0] addr_base = addr_sel_sync ? ADDR_BASE_SEL1 : ADDR_BASE_SEL0;
      wire [4:0] addr_at_release = addr_base + 5'(p);
      // chosen write data: loader beats host
      wire [`PSM_DATA_W-1:0] wdata = load_wr ? cfg_load_data : mgmt_wdata;
      wire any_wr = load_wr | host_wr;

      // strap default latch
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mode_default <= 3'h0;
        end else if (release_now) begin
          mode_default <= mode_at_release;
        end
      end

      // mode field: release, port reset, loader, host in that order
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mode <= 3'h0;
        end else if (release_now) begin
          mode <= mode_at_release;
        end else if (port_phy_reset[p]) begin
          mode <= mode_default;
        end else if (any_wr) begin
          mode <= wdata[`PSM_MODE_MSB:`PSM_MODE_LSB];
        end
      end

      // address field: release default, then loader or host
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          addr <= 5'h00;
        end else if (release_now) begin
          addr <= addr_at_release;
        end else if (any_wr) begin
          addr <= wdata[`PSM_ADDR_MSB:`PSM_ADDR_LSB];
        end
      end

      assign eff = decode_mode(mode);
      assign mode_all[3*p +: 3] = mode;
      assign addr_all[5*p +: 5] = addr;

      // registered outputs follow the stored fields
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          phy_mgmt_address[5*p +: 5] <= 5'h00;
          scrambler_seed[5*p +: 5] <= 5'h00;
          ctrl_drive[4*p +: 4] <= 4'h0;
          ctrl_value[4*p +: 4] <= 4'h0;
          adv_drive[4*p +: 4] <= 4'h0;
          adv_value[4*p +: 4] <= 4'h0;
          power_down[p] <= 1'b0;
          repeater_mode[p] <= 1'b0;
          crs_on_tx[p] <= 1'b0;
        end else begin
          phy_mgmt_address[5*p +: 5] <= addr;
          scrambler_seed[5*p +: 5] <= addr;
          ctrl_drive[4*p +: 4] <= eff.ctrl_drive;
          ctrl_value[4*p +: 4] <= eff.ctrl_value;
          adv_drive[4*p +: 4] <= eff.adv_drive;
          adv_value[4*p +: 4] <= eff.adv_value;
          power_down[p] <= eff.power_down;
          repeater_mode[p] <= eff.repeater;
          crs_on_tx[p] <= eff.crs_on_tx;
        end
      end
    end
  endgenerate

  // reads see the stored fields, not the registered outputs,
  // so a read right after a write already gives the new value
  // a read in the same cycle as a write returns the old word
  // a miss, wrong index or port, returns zero and no valid
  // the reserved byte is a constant, written data never
  // reaches it, so it always reads back as zero
  // read data: reserved byte zero, fields from the selected port
  wire [2:0] rd_mode = mode_all[3*mgmt_port +: 3];
  wire [4:0] rd_addr = addr_all[5*mgmt_port +: 5];
  wire [`PSM_DATA_W-1:0] rd_word = {`PSM_RESERVED_VALUE, rd_mode, rd_addr};
  wire [`PSM_DATA_W-1:0] next_rdata = rd_hit ? rd_word : 16'h0000;

  // the answer stands for exactly one cycle
  // data falls back to zero when no read hits,
  // so a stale word cannot be mistaken for a new one
  // read answer register, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mgmt_rdata <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rdata <= next_rdata;
      mgmt_rvalid <= rd_hit;
    end
  end

endmodule : phy_special_modes_register

// File: verification/phy_special_modes_register_assertions.sv
`timescale 1ns/10ps
`include "phy_special_modes_defines.svh"
// watches access timing and the port 0 mode decode
module phy_special_modes_register_assertions #(
  parameter int NUM_PORTS = 2,
  parameter int PORT_W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mgmt_wr_en,
  input wire logic mgmt_rd_en,
  input wire logic [PORT_W-1:0] mgmt_port,
  input wire logic [`PSM_INDEX_W-1:0] mgmt_index,
  input wire logic [`PSM_DATA_W-1:0] mgmt_wdata,
  input wire logic [`PSM_DATA_W-1:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  input wire logic cfg_load_en,
  input wire logic [PORT_W-1:0] cfg_load_port,
  input wire logic [`PSM_DATA_W-1:0] cfg_load_data,
  input wire logic [NUM_PORTS-1:0] port_phy_reset,
  input wire logic [5*NUM_PORTS-1:0] phy_mgmt_address,
  input wire logic [5*NUM_PORTS-1:0] scrambler_seed,
  input wire logic [4*NUM_PORTS-1:0] ctrl_drive,
  input wire logic [4*NUM_PORTS-1:0] ctrl_value,
  input wire logic [4*NUM_PORTS-1:0] adv_drive,
  input wire logic [4*NUM_PORTS-1:0] adv_value,
  input wire logic [NUM_PORTS-1:0] power_down
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic was_up;  // reset already high one edge ago
  // tracks the release cycle, which overrides accesses
  always_ff @(posedge clk) begin
    was_up <= rst_n;
  end
  wire logic live = rst_n && was_up;  // past the release cycle
  wire logic hit = mgmt_index == `PSM_REG_INDEX;  // this register addressed
  wire logic load0 = cfg_load_en && cfg_load_port == '0;  // loader on port 0
  // host write to port 0 that nothing overrides
  wire logic wr0 = live && mgmt_wr_en && hit && mgmt_port == '0 && !load0 && !port_phy_reset[0];
  property p_rd_hit;
    live && mgmt_rd_en && hit |=> mgmt_rvalid;
  endproperty
  a_rd_hit: assert property (p_rd_hit) else $error("read gave no rvalid");
  property p_rd_miss;
    !(mgmt_rd_en && hit) |=> !mgmt_rvalid && mgmt_rdata == '0;
  endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("rvalid without read");
  property p_rsv;
    mgmt_rvalid |-> mgmt_rdata[15:8] == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("upper byte not zero");
  property p_wr_addr;
    wr0 |-> ##2 phy_mgmt_address[4:0] == $past(mgmt_wdata[4:0], 2);
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("address not written");
  property p_seed;
    scrambler_seed == phy_mgmt_address;
  endproperty
  a_seed: assert property (p_seed) else $error("seed differs from address");
  property p_load;
    live && load0 |-> ##2 phy_mgmt_address[4:0] == $past(cfg_load_data[4:0], 2);
  endproperty
  a_load: assert property (p_load) else $error("loader word not taken");
  property p_mode0;
    wr0 && mgmt_wdata[7:5] == 3'h0 |-> ##2 ctrl_drive[3:0] == 4'hf && ctrl_value[3:0] == 4'h0;
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode 0 decode wrong");
  property p_all_cap;
    wr0 && mgmt_wdata[7:5] == 3'h7 |-> ##2 ctrl_drive[3:0] == 4'h6 && ctrl_value[3:0] == 4'h4
      && adv_drive[3:0] == 4'hf && adv_value[3:0] == 4'hf;
  endproperty
  a_all_cap: assert property (p_all_cap) else $error("mode 7 decode wrong");
  property p_pwr;
    power_down[0] |-> ctrl_drive[3:0] == 4'h0 && adv_drive[3:0] == 4'h0;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-down drives bits");
endmodule : phy_special_modes_register_assertions

bind phy_special_modes_register phy_special_modes_register_assertions #(
  .NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)) u_chk (.clk(clk), .rst_n(rst_n),
  .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en), .mgmt_port(mgmt_port),
  .mgmt_index(mgmt_index), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
  .mgmt_rvalid(mgmt_rvalid), .cfg_load_en(cfg_load_en), .cfg_load_port(cfg_load_port),
  .cfg_load_data(cfg_load_data), .port_phy_reset(port_phy_reset),
  .phy_mgmt_address(phy_mgmt_address), .scrambler_seed(scrambler_seed),
  .ctrl_drive(ctrl_drive), .ctrl_value(ctrl_value), .adv_drive(adv_drive),
  .adv_value(adv_value), .power_down(power_down));

// File: verification/mgmt_host_model.sv
`timescale 1ns/10ps
`include "phy_special_modes_defines.svh"
// management host: at most one access per call, launched 1 ns after an edge
module mgmt_host_model (
  input wire logic clk,
  output logic mgmt_wr_en,
  output logic mgmt_rd_en,
  output logic mgmt_port,
  output logic [`PSM_INDEX_W-1:0] mgmt_index,
  output logic [`PSM_DATA_W-1:0] mgmt_wdata,
  input wire logic [`PSM_DATA_W-1:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  logic [4:0] given [2];  // low five bits this host last wrote to each port, at any index
  // idle bus at time zero
  initial begin
    mgmt_wr_en = 1'b0;
    mgmt_rd_en = 1'b0;
    mgmt_port = 1'b0;
    mgmt_index = 5'h00;
    mgmt_wdata = 16'h0000;
  end
  // write; a register write whose address equals the low bits last written to the other port is dropped
  task automatic wr(input logic p, input logic [4:0] idx, input logic [15:0] d);
    @(posedge clk);
    #1;
    if (idx == `PSM_REG_INDEX && given[~p] === d[4:0]) begin
      return;
    end
    given[p] = d[4:0];
    mgmt_port = p;
    mgmt_index = idx;
    mgmt_wdata = d;
    mgmt_wr_en = 1'b1;
    @(posedge clk);
    #1;
    mgmt_wr_en = 1'b0;
    mgmt_wdata = ~d;  // released lines do not keep old data
    mgmt_index = ~idx;
  endtask : wr
  // read; answer lands one edge after the strobe
  task automatic rd(input logic p, input logic [4:0] idx, output logic [15:0] q,
    output logic v);
    @(posedge clk);
    #1;
    mgmt_port = p;
    mgmt_index = idx;
    mgmt_rd_en = 1'b1;
    @(posedge clk);
    #1;
    mgmt_rd_en = 1'b0;
    mgmt_index = ~idx;
    q = mgmt_rdata;
    v = mgmt_rvalid;
  endtask : rd
endmodule : mgmt_host_model

// File: verification/phy_special_modes_register_tb.sv
`timescale 1ns/10ps
`include "phy_special_modes_defines.svh"
module phy_special_modes_register_tb;
  logic clk, rst_n, mgmt_wr_en, mgmt_rd_en, mgmt_port, mgmt_rvalid, v;
  logic cfg_load_en, cfg_load_port, phy_addr_sel_strap;
  logic [4:0] mgmt_index;
  logic [15:0] mgmt_wdata, mgmt_rdata, cfg_load_data, q;
  logic [1:0] port_phy_reset, autoneg_strap, speed_strap, duplex_strap;
  logic [1:0] power_down, repeater_mode, crs_on_tx;
  logic [9:0] phy_mgmt_address, scrambler_seed;
  logic [7:0] ctrl_drive, ctrl_value, adv_drive, adv_value;
  int mismatches, checked;
  // port 0 decode: drives, masked values, power-down, repeater, carrier on tx
  wire logic [18:0] seen_mode = {ctrl_drive[3:0], ctrl_value[3:0] & ctrl_drive[3:0],
    adv_drive[3:0], adv_value[3:0] & adv_drive[3:0], power_down[0], repeater_mode[0],
    crs_on_tx[0]};
  // mode code beside the decode it should give
  logic [21:0] rows [8] = '{{3'h0, 4'hf, 4'h0, 4'h0, 4'h0, 3'h0},
    {3'h1, 4'hf, 4'h1, 4'h0, 4'h0, 3'h0}, {3'h2, 4'hf, 4'h8, 4'h0, 4'h0, 3'h1},
    {3'h3, 4'hf, 4'h9, 4'h0, 4'h0, 3'h0}, {3'h4, 4'hf, 4'hc, 4'hf, 4'h4, 3'h1},
    {3'h5, 4'hf, 4'hc, 4'hf, 4'h4, 3'h2}, {3'h6, 4'h0, 4'h0, 4'h0, 4'h0, 3'h4},
    {3'h7, 4'h6, 4'h4, 4'hf, 4'hf, 3'h1}};
  phy_special_modes_register #(.NUM_PORTS(2), .PORT_W(1)) u_dut (.clk(clk), .rst_n(rst_n),
    .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en), .mgmt_port(mgmt_port),
    .mgmt_index(mgmt_index), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .cfg_load_en(cfg_load_en), .cfg_load_port(cfg_load_port),
    .cfg_load_data(cfg_load_data), .port_phy_reset(port_phy_reset),
    .autoneg_strap(autoneg_strap), .speed_strap(speed_strap), .duplex_strap(duplex_strap),
    .phy_addr_sel_strap(phy_addr_sel_strap), .phy_mgmt_address(phy_mgmt_address),
    .scrambler_seed(scrambler_seed), .ctrl_drive(ctrl_drive), .ctrl_value(ctrl_value),
    .adv_drive(adv_drive), .adv_value(adv_value), .power_down(power_down),
    .repeater_mode(repeater_mode), .crs_on_tx(crs_on_tx));
  mgmt_host_model u_host (.clk(clk), .mgmt_wr_en(mgmt_wr_en), .mgmt_rd_en(mgmt_rd_en),
    .mgmt_port(mgmt_port), .mgmt_index(mgmt_index), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));
  // compare and count
  task automatic chk(input logic [18:0] seen, input logic [18:0] want);
    checked++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : chk
  // read this register and expect a word
  task automatic rdc(input logic p, input logic [15:0] want);
    u_host.rd(p, `PSM_REG_INDEX, q, v);
    chk({18'h0, v}, 19'h1);
    chk({3'h0, q}, {3'h0, want});
  endtask : rdc
  // one-cycle loader or port reset pulse
  task automatic pulse(input logic [1:0] rs, input logic ld);
    @(posedge clk);
    #1;
    port_phy_reset = rs;
    cfg_load_en = ld;
    @(posedge clk);
    #1;
    port_phy_reset = 2'h0;
    cfg_load_en = 1'b0;
  endtask : pulse
  // hold reset six cycles
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
  endtask : do_reset
  task automatic end_sim();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  // main sequence
  initial begin
    cfg_load_en = 1'b0;
    cfg_load_port = 1'b0;
    cfg_load_data = 16'hff23;  // reserved bits set, mode 1, address 3
    port_phy_reset = 2'h0;
    autoneg_strap = 2'h1;
    speed_strap = 2'h2;
    duplex_strap = 2'h2;
    phy_addr_sel_strap = 1'b1;
    do_reset();
    rdc(1'b0, 16'h00f1);
    rdc(1'b1, 16'h0072);
    // every mode code on port 0
    for (int i = 0; i < 8; i++) begin
      u_host.wr(1'b0, `PSM_REG_INDEX, {8'hff, rows[i][21:19], 5'h05});
      rdc(1'b0, {8'h00, rows[i][21:19], 5'h05});
      chk(seen_mode, rows[i][18:0]);
    end
    // other index neither answers nor writes
    u_host.rd(1'b0, 5'h11, q, v);
    chk({2'h0, q, v}, 19'h0);
    u_host.wr(1'b0, 5'h11, 16'h0000);
    rdc(1'b0, 16'h00e5);
    pulse(2'h0, 1'b1);
    rdc(1'b0, 16'h0023);
    // straps move after release; port reset still uses captured values
    autoneg_strap = 2'h0;
    speed_strap = 2'h1;
    duplex_strap = 2'h0;
    phy_addr_sel_strap = 1'b0;
    repeat (5) @(posedge clk);
    pulse(2'h3, 1'b0);
    rdc(1'b0, 16'h00e3);
    rdc(1'b1, 16'h0072);
    do_reset();
    rdc(1'b0, 16'h0041);
    rdc(1'b1, 16'h0002);
    end_sim();
  end
endmodule : phy_special_modes_register_tb
